//--- sram_map.vh
// constants shared by the pipelined burst memory
`ifndef SRAM_MAP_VH
`define SRAM_MAP_VH

// word and lane layout
`define WORD_W_X36 36
`define LANES_X36 4
`define ADDR_W_X36 18
`define WORD_W_X18 18
`define LANES_X18 2
`define ADDR_W_X18 19
`define LANE_W 9
`define LANE_PARITY_POS 8

// array depth of each organisation
`define DEPTH_X36 262144
`define DEPTH_X18 524288

// burst counter
`define BURST_W 2
`define BURST_FIRST 2'h0
`define BURST_STEP 2'h1

// burst order select level
`define ORDER_LINEAR 1'b1
`define ORDER_INTERLEAVED 1'b0

// reset values
`define RESET_BIT 1'b0
`define RESET_HIGH 1'b1

`endif

//--- burst_counter.v
`timescale 1ns/1ns
`include "sram_map.vh"

// two-bit burst address generator
module burst_counter (
   // clock and reset
   input wire clk_sys,
   input wire reset,
   // control from the access decoder
   input wire load,
   input wire [`BURST_W-1:0] load_lo,
   input wire step,
   input wire linear,
   // low address bits for this cycle
   output wire [`BURST_W-1:0] burst_lo
);

   reg [`BURST_W-1:0] base_q; // low bits of the start address
   reg [`BURST_W-1:0] cnt_q; // beats advanced so far
   reg [`BURST_W-1:0] base_d;
   reg [`BURST_W-1:0] cnt_d;

   // address order: linear adds, interleaved exclusive-ors
   function [`BURST_W-1:0] order_addr;
      input [`BURST_W-1:0] base;
      input [`BURST_W-1:0] cnt;
      input lin;
      begin
         if (lin == `ORDER_LINEAR) begin
            order_addr = base + cnt;
         end else begin
            order_addr = base ^ cnt;
         end
      end
   endfunction

   // next base and count
   always @* begin
      if (load) begin
         base_d = load_lo;
         cnt_d = `BURST_FIRST;
      end else if (step) begin
         base_d = base_q;
         cnt_d = cnt_q + `BURST_STEP;
      end else begin
         base_d = base_q;
         cnt_d = cnt_q;
      end
   end

   // counter state
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         base_q <= `BURST_FIRST;
         cnt_q <= `BURST_FIRST;
      end else begin
         base_q <= base_d;
         cnt_q <= cnt_d;
      end
   end

   // address seen by the array this cycle
   assign burst_lo = order_addr(base_d, cnt_d, linear);

endmodule

//--- lane_memory.v
`timescale 1ns/1ns
`include "sram_map.vh"

// storage array with lane writes and registered read data
module lane_memory #(
   parameter WORD_W = `WORD_W_X36,
   parameter LANES = `LANES_X36,
   parameter ADDR_W = `ADDR_W_X36
) (
   // clock
   input wire clk_sys,
   // access port
   input wire en,
   input wire [LANES-1:0] lane_we,
   input wire [ADDR_W-1:0] addr,
   input wire [WORD_W-1:0] wdata,
   output reg [WORD_W-1:0] rdata_q
);

   reg [WORD_W-1:0] mem [0:(1<<ADDR_W)-1]; // the cells
   integer i;

   // write selected lanes, nine bits each, else read
   always @(posedge clk_sys) begin
      if (en) begin
         if (|lane_we) begin
            for (i = 0; i < LANES; i = i + 1) begin
               if (lane_we[i]) begin
                  mem[addr][i*`LANE_W +: `LANE_W] <=
                     wdata[i*`LANE_W +: `LANE_W];
               end
            end
         end else begin
            rdata_q <= mem[addr];
         end
      end
   end

endmodule

//--- pipelined_burst_sync_sram.v
`timescale 1ns/1ns
`include "sram_map.vh"

// Behaviour
// - every synchronous input captured on rising edge
// - strobe active latches address and chip enables
// - two-bit counter steps only on burst advance
// - interleaved or linear burst order selectable
// - registered write completes without further strobes
// - under byte write master, only enabled byte lanes get written
// - global write low writes all lanes
// - output enable acts asynchronously, sleep through two flip-flops
// - first word three clocks, then one each
// - deselect takes outputs off after one cycle
// - 256K x 36 or 512K x 18 organisation
module pipelined_burst_sync_sram #(
   parameter WORD_W = `WORD_W_X36,
   parameter LANES = `LANES_X36,
   parameter ADDR_W = `ADDR_W_X36
) (
   // clock and reset
   input wire clk_sys,
   input wire reset,
   // address and chip selects
   input wire [ADDR_W-1:0] addr,
   input wire chip_select_primary_n,
   input wire chip_select_depth_high,
   input wire chip_select_depth_low_n,
   // burst control
   input wire processor_addr_strobe_n,
   input wire controller_addr_strobe_n,
   input wire burst_step_n,
   input wire burst_order_linear,
   // write control
   input wire [LANES-1:0] lane_write_n,
   input wire byte_write_master_n,
   input wire global_write_n,
   // asynchronous controls
   input wire output_enable_n,
   input wire sleep_request,
   // data bus, lane bit 8 is the lane_parity_bit
   input wire [WORD_W-1:0] dq_in,
   output wire [WORD_W-1:0] dq_out,
   output wire [WORD_W-1:0] dq_oe,
   // sleep state seen by the core
   output wire asleep
);

   ////////////////////////////////////////////////////////////////////////
   // input registers

   reg [ADDR_W-1:0] addr_q; // sampled address
   reg cs_primary_n_q; // sampled primary select
   reg cs_high_q; // sampled depth select, active high
   reg cs_low_n_q; // sampled depth select, active low
   reg proc_strobe_n_q; // sampled processor strobe
   reg ctrl_strobe_n_q; // sampled controller strobe
   reg step_n_q; // sampled burst advance
   reg [LANES-1:0] lane_n_q; // sampled lane writes
   reg master_n_q; // sampled byte write master
   reg global_n_q; // sampled global write
   reg [WORD_W-1:0] din_q; // sampled write data

   // capture every synchronous pin on the rising edge
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         addr_q <= {ADDR_W{`RESET_BIT}};
         cs_primary_n_q <= `RESET_HIGH;
         cs_high_q <= `RESET_BIT;
         cs_low_n_q <= `RESET_HIGH;
         proc_strobe_n_q <= `RESET_HIGH;
         ctrl_strobe_n_q <= `RESET_HIGH;
         step_n_q <= `RESET_HIGH;
         lane_n_q <= {LANES{`RESET_HIGH}};
         master_n_q <= `RESET_HIGH;
         global_n_q <= `RESET_HIGH;
         din_q <= {WORD_W{`RESET_BIT}};
      end else begin
         addr_q <= addr;
         cs_primary_n_q <= chip_select_primary_n;
         cs_high_q <= chip_select_depth_high;
         cs_low_n_q <= chip_select_depth_low_n;
         proc_strobe_n_q <= processor_addr_strobe_n;
         ctrl_strobe_n_q <= controller_addr_strobe_n;
         step_n_q <= burst_step_n;
         lane_n_q <= lane_write_n;
         master_n_q <= byte_write_master_n;
         global_n_q <= global_write_n;
         din_q <= dq_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sleep and the static order strap through two flip-flops

   reg sleep_meta_q; // first stage, read only by the second
   reg sleep_q; // synchronised sleep level
   reg order_meta_q; // first stage of the order strap
   reg order_q; // synchronised burst order

   // two-stage synchronisers for sleep and the order strap
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sleep_meta_q <= `RESET_BIT;
         sleep_q <= `RESET_BIT;
         order_meta_q <= `ORDER_INTERLEAVED;
         order_q <= `ORDER_INTERLEAVED;
      end else begin
         sleep_meta_q <= sleep_request;
         sleep_q <= sleep_meta_q;
         order_meta_q <= burst_order_linear;
         order_q <= order_meta_q;
      end
   end

   assign asleep = sleep_q;

   ////////////////////////////////////////////////////////////////////////
   // access decode

   wire selected; // all chip enables true
   wire proc_start; // processor strobe honoured
   wire any_start; // some strobe begins an access
   wire go; // access begins on a selected part
   wire deselect; // access begins on a deselected part
   reg [LANES-1:0] wr_lanes; // lanes to write this cycle
   wire wr_any; // some lane is written

   // lane mask from global, master and lane controls
   function [LANES-1:0] lane_mask;
      input global_n;
      input master_n;
      input [LANES-1:0] lanes_n;
      begin
         if (!global_n) begin
            lane_mask = {LANES{1'b1}};
         end else if (!master_n) begin
            lane_mask = ~lanes_n;
         end else begin
            lane_mask = {LANES{1'b0}};
         end
      end
   endfunction

   assign selected = !cs_primary_n_q && cs_high_q && !cs_low_n_q;
   // processor strobe is ignored while the primary select is high
   assign proc_start = !proc_strobe_n_q && !cs_primary_n_q;
   assign any_start = (proc_start || !ctrl_strobe_n_q) && !sleep_q;
   assign go = any_start && selected;
   assign deselect = any_start && !selected;

   // processor-strobe starts are always reads
   always @* begin
      if (any_start && proc_start) begin
         wr_lanes = {LANES{1'b0}};
      end else begin
         wr_lanes = lane_mask(global_n_q, master_n_q, lane_n_q);
      end
   end

   assign wr_any = |wr_lanes;

   ////////////////////////////////////////////////////////////////////////
   // burst tracking

   reg active_q; // a burst is open
   reg [ADDR_W-`BURST_W-1:0] upper_q; // upper address of the burst
   wire [`BURST_W-1:0] burst_lo; // counter address bits
   wire step; // advance requested inside a burst
   wire [ADDR_W-1:0] acc_addr; // address of this cycle's access
   wire acc_en; // array accessed this cycle
   wire rd_issue; // read handed to the array

   assign step = active_q && !any_start && !step_n_q && !sleep_q;

   // internal burst counter
   burst_counter u_counter (
      .clk_sys(clk_sys),
      .reset(reset),
      .load(go),
      .load_lo(addr_q[`BURST_W-1:0]),
      .step(step),
      .linear(order_q),
      .burst_lo(burst_lo)
   );

   // open on a selected start, close on deselect or sleep
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         active_q <= `RESET_BIT;
         upper_q <= {(ADDR_W-`BURST_W){`RESET_BIT}};
      end else begin
         if (go) begin
            active_q <= 1'b1;
            upper_q <= addr_q[ADDR_W-1:`BURST_W];
         end else if (deselect || sleep_q) begin
            active_q <= 1'b0;
         end
      end
   end

   // start uses the fresh address, otherwise the burst address
   assign acc_addr = go ? {addr_q[ADDR_W-1:`BURST_W], burst_lo} :
                     {upper_q, burst_lo};
   assign acc_en = (go || (active_q && !any_start)) && !sleep_q;
   assign rd_issue = acc_en && !wr_any;

   ////////////////////////////////////////////////////////////////////////
   // storage array

   wire [WORD_W-1:0] rdata; // registered array output

   // self-timed write from the registered data and lanes
   lane_memory #(
      .WORD_W(WORD_W),
      .LANES(LANES),
      .ADDR_W(ADDR_W)
   ) u_array (
      .clk_sys(clk_sys),
      .en(acc_en),
      .lane_we(acc_en ? wr_lanes : {LANES{1'b0}}),
      .addr(acc_addr),
      .wdata(din_q),
      .rdata_q(rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // output pipeline

   reg rd_pipe_q; // array read data is valid
   reg [WORD_W-1:0] dout_q; // output register
   reg out_valid_q; // output register holds read data
   wire kill; // drop the output early

   // deselect, write or sleep turn the drivers off after one cycle
   assign kill = deselect || (acc_en && wr_any) || sleep_q;

   // array stage then output stage, 3-1-1-1 timing
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rd_pipe_q <= `RESET_BIT;
         dout_q <= {WORD_W{`RESET_BIT}};
         out_valid_q <= `RESET_BIT;
      end else begin
         rd_pipe_q <= rd_issue;
         if (rd_pipe_q) begin
            dout_q <= rdata;
         end
         if (kill) begin
            out_valid_q <= 1'b0;
         end else begin
            out_valid_q <= rd_pipe_q;
         end
      end
   end

   // output enable gates the drivers with no clock in the path
   assign dq_out = dout_q;
   assign dq_oe = {WORD_W{out_valid_q && !output_enable_n}};

endmodule

//--- sram_pin_assertions.sv
`timescale 1ns/1ns
// pin-level timing of the memory's data drivers
module sram_pin_checker #(
   parameter WORD_W = 36,
   parameter LANES = 4,
   parameter ADDR_W = 18
) (
   // clock and reset
   input wire clk_sys,
   input wire reset,
   // selects and strobes
   input wire chip_select_primary_n,
   input wire chip_select_depth_high,
   input wire chip_select_depth_low_n,
   input wire processor_addr_strobe_n,
   input wire controller_addr_strobe_n,
   // write and asynchronous controls
   input wire [LANES-1:0] lane_write_n,
   input wire byte_write_master_n,
   input wire global_write_n,
   input wire output_enable_n,
   input wire sleep_request,
   // outputs watched
   input wire [WORD_W-1:0] dq_oe,
   input wire asleep
);
   ////////////////////////////////////////////////////////////////
   // decoded start conditions
   wire sel = !chip_select_primary_n && chip_select_depth_high
      && !chip_select_depth_low_n;
   wire wr_ctl = !global_write_n
      || (!byte_write_master_n && !(&lane_write_n));
   // controller start that the memory will take
   wire go = !controller_addr_strobe_n && !asleep && !sleep_request;
   wire rd_go = go && sel && !wr_ctl;
   // plain read beat with drivers allowed
   wire quiet = controller_addr_strobe_n && processor_addr_strobe_n
      && !wr_ctl && !output_enable_n && !sleep_request && !asleep;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////
   a_oe_gates_drivers: assert property (
      output_enable_n |-> dq_oe == '0) else $error("drivers on, oe off");
   a_lanes_drive_together: assert property (
      dq_oe == '0 || dq_oe == '1) else $error("lane enables split");
   a_read_first_word: assert property (
      rd_go ##1 quiet [*3] |-> dq_oe == '1)
      else $error("first word not out after three clocks");
   a_deselect_release: assert property (
      go && !sel |-> ##2 dq_oe == '0)
      else $error("bus held after deselect");
   a_write_release: assert property (
      go && sel && wr_ctl |-> ##2 dq_oe == '0)
      else $error("bus held after write");
   a_sleep_entry: assert property (
      sleep_request [*3] |=> asleep) else $error("sleep not entered");
   a_sleep_exit: assert property (
      !sleep_request [*3] |=> !asleep) else $error("sleep not left");
   a_sleep_quiet: assert property (
      asleep ##1 asleep |-> dq_oe == '0) else $error("drivers on asleep");
   // main scenarios seen
   c_read: cover property (rd_go ##1 quiet [*3]);
   c_deselect: cover property (go && !sel);
   c_sleep: cover property (asleep);
endmodule

bind pipelined_burst_sync_sram sram_pin_checker #(.WORD_W(WORD_W),
   .LANES(LANES), .ADDR_W(ADDR_W)) chk_u (.clk_sys, .reset,
   .chip_select_primary_n, .chip_select_depth_high,
   .chip_select_depth_low_n, .processor_addr_strobe_n,
   .controller_addr_strobe_n, .lane_write_n, .byte_write_master_n,
   .global_write_n, .output_enable_n, .sleep_request, .dq_oe, .asleep);

//--- host_bus_model.sv
`timescale 1ns/1ns
// host side: drives the memory bus one beat per clock
module host_bus_model (
   // clock
   input wire clk_sys,
   // bus toward the memory
   output logic [17:0] addr,
   output logic chip_select_primary_n,
   output logic chip_select_depth_high,
   output logic chip_select_depth_low_n,
   output logic processor_addr_strobe_n,
   output logic controller_addr_strobe_n,
   output logic burst_step_n,
   output logic [3:0] lane_write_n,
   output logic byte_write_master_n,
   output logic global_write_n,
   output logic [35:0] dq_in,
   // read data back
   input wire [35:0] dq_out
);
   ////////////////////////////////////////////////////////////////
   // park the bus: no strobe, no write, data flipped so stale
   // values never look valid
   // burst advance is left to read4, so it is set once per time step
   task automatic idle();
      processor_addr_strobe_n = 1'b1;
      controller_addr_strobe_n = 1'b1;
      {global_write_n, byte_write_master_n} = 2'h3;
      lane_write_n = 4'hF;
      dq_in = ~dq_in;
   endtask
   initial begin
      addr = 18'h00000;
      dq_in = 36'h0;
      {chip_select_primary_n, chip_select_depth_high} = 2'h1;
      chip_select_depth_low_n = 1'b0;
      burst_step_n = 1'b1;
      idle();
   end
   // one strobed beat, entered and left just after an edge
   task automatic start(input logic [17:0] a, input logic ctl,
      input logic [2:0] cs, input logic [1:0] wr, input logic [3:0] ln,
      input logic [35:0] d);
      addr = a;
      {chip_select_primary_n, chip_select_depth_high,
         chip_select_depth_low_n} = cs;
      processor_addr_strobe_n = ctl;
      controller_addr_strobe_n = ~ctl;
      {global_write_n, byte_write_master_n} = wr;
      lane_write_n = ln;
      dq_in = d;
      @(posedge clk_sys);
      #1;
      idle();
   endtask
   // read start, then advance on each beat and take four words
   task automatic read4(input logic [17:0] a, input logic ctl,
      output logic [143:0] w);
      start(a, ctl, 3'h2, 2'h3, 4'hF, dq_in);
      burst_step_n = 1'b0;
      repeat (2) @(posedge clk_sys);
      for (int i = 0; i < 4; i++) begin
         #3;
         w[36*i +: 36] = dq_out;
         @(posedge clk_sys);
         #1;
      end
      burst_step_n = 1'b1;
   endtask
endmodule

//--- tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, e, s) begin cmp_count++; if ((e) !== (s)) begin \
   miscompares++; $display("mismatch %s exp %h got %h", nm, e, s); \
   end end
// self-checking bench for the burst memory
module tb_top;
   ////////////////////////////////////////////////////////////////
   // pins of the memory
   logic clk_sys, reset, burst_order_linear, output_enable_n;
   logic sleep_request, chip_select_primary_n, chip_select_depth_high;
   logic chip_select_depth_low_n, processor_addr_strobe_n;
   logic controller_addr_strobe_n, burst_step_n, byte_write_master_n;
   logic global_write_n, asleep;
   logic [17:0] addr;
   logic [3:0] lane_write_n;
   logic [35:0] dq_in, dq_out, dq_oe;
   // score and mirror of the array
   int miscompares = 0;
   int cmp_count = 0;
   logic [35:0] mem [logic [17:0]];
   pipelined_burst_sync_sram dut_u (.clk_sys, .reset, .addr,
      .chip_select_primary_n, .chip_select_depth_high,
      .chip_select_depth_low_n, .processor_addr_strobe_n,
      .controller_addr_strobe_n, .burst_step_n, .burst_order_linear,
      .lane_write_n, .byte_write_master_n, .global_write_n,
      .output_enable_n, .sleep_request, .dq_in, .dq_out, .dq_oe, .asleep);
   host_bus_model host_u (.clk_sys, .addr, .chip_select_primary_n,
      .chip_select_depth_high, .chip_select_depth_low_n,
      .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_step_n,
      .lane_write_n, .byte_write_master_n, .global_write_n, .dq_in,
      .dq_out);
   ////////////////////////////////////////////////////////////////
   // lanes a write should touch, wr is {global, master}
   function automatic logic [35:0] merge(input logic [35:0] o, d,
      input logic [1:0] wr, input logic [3:0] ln);
      for (int i = 0; i < 4; i++)
         if (!wr[1] || (!wr[0] && !ln[i]))
            o[9*i +: 9] = d[9*i +: 9];
      return o;
   endfunction
   // address of beat n in the selected order
   function automatic logic [17:0] baddr(input logic [17:0] a, int n);
      baddr = a;
      baddr[1:0] = burst_order_linear ? a[1:0] + 2'(n) : a[1:0] ^ 2'(n);
   endfunction
   task automatic wr1(input logic [17:0] a, input logic [1:0] wr,
      input logic [3:0] ln, input logic [35:0] d);
      host_u.start(a, 1'b1, 3'h2, wr, ln, d);
      mem[a] = merge(mem[a], d, wr, ln);
      // let an edge pass so the next request is not set in this step
      @(posedge clk_sys);
      #1;
   endtask
   task automatic rd4(input logic [17:0] a, input logic ctl);
      logic [143:0] w;
      host_u.read4(a, ctl, w);
      for (int n = 0; n < 4; n++)
         `CHK("word", mem[baddr(a, n)], w[36*n +: 36])
   endtask
   // start that must leave the bus undriven
   task automatic off_chk(input logic ctl, input logic [2:0] cs);
      host_u.start(18'h0, ctl, cs, 2'h3, 4'hF, 36'h0);
      repeat (4) begin
         @(posedge clk_sys);
         #1;
         `CHK("dq_oe", 36'h0, dq_oe)
      end
   endtask
   task automatic tally_and_finish();
      if (miscompares == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // clock and watchdog
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial begin
      #100000;
      miscompares++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      void'($urandom(54));
      reset = 1'b1;
      burst_order_linear = 1'b0;
      output_enable_n = 1'b0;
      sleep_request = 1'b0;
      repeat (8) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      // fill the window with global writes, lane bits ignored
      for (int i = 0; i < 16; i++)
         wr1({14'h3FFF, 4'(i)}, 2'h1, 4'($urandom),
            36'({$urandom, $urandom}));
      // random global, lane or no writes then bursts read straight after
      repeat (24) begin
         burst_order_linear = 1'($urandom);
         repeat (3) @(posedge clk_sys);
         #1;
         wr1({14'h3FFF, 4'($urandom)}, 2'($urandom % 3 + 1),
            4'($urandom), 36'({$urandom, $urandom}));
         rd4({14'h3FFF, 4'($urandom)}, 1'($urandom));
      end
      // deselects and a refused processor start
      off_chk(1'b1, 3'h6);
      off_chk(1'b1, 3'h0);
      off_chk(1'b1, 3'h3);
      off_chk(1'b0, 3'h6);
      // output enable cuts the drivers between edges
      rd4({14'h3FFF, 4'h2}, 1'b0);
      output_enable_n = 1'b1;
      #1;
      `CHK("dq_oe", 36'h0, dq_oe)
      output_enable_n = 1'b0;
      #1;
      `CHK("dq_oe", 36'hF_FFFF_FFFF, dq_oe)
      @(posedge clk_sys);
      #1;
      // sleep: starts refused, then normal again
      sleep_request = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      `CHK("asleep", 1'b1, asleep)
      off_chk(1'b1, 3'h2);
      sleep_request = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      `CHK("asleep", 1'b0, asleep)
      rd4({14'h3FFF, 4'h3}, 1'b1);
      tally_and_finish();
   end
endmodule
